// *** pkg/charge_time_pkg.sv ***
// constants, field positions and source codes of the charge-time edge control
// assumes one 32-bit control register reached over a plain strobe port
// What this block does
// - edge1 sampling bit picks edge or level; polarity
// - edge2 sampling bit picks edge or level; polarity
// - edge1 source field selects one of sixteen triggers
// - edge2 source field selects one of sixteen triggers
// - edge2 status reads occurrence, software may write it
// - edge1 status reads occurrence, software may write it
// - module runs only while enable bit set
// - stop-in-idle halts module during device idle
// - time-generation bit enables edge delay pulse
// - edge-pass bit clear blocks all incoming edges
// - sequence bit makes edge2 wait for edge1
// - discharge bit grounds the current source output
// - trigger-control bit enables the trigger output
// - six-bit two's-complement trim adjusts current
// - two-bit range field scales the current source
// - unimplemented bits read zero, fields reset zero
package charge_time_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int SRC_W = 16;
	localparam int PIN_N = 13;
	localparam int CAP_N = 3;
	localparam int CMP_N = 3;
	localparam int SYNC_W = PIN_N + CMP_N;

	localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h00;
	localparam logic [DATA_W-1:0] CTRL_RESET = 32'h00000000;
	localparam logic [DATA_W-1:0] CTRL_IMPL_MASK = 32'hFFFCBFFF;

	localparam int EDGE1_MODE_BIT = 31;
	localparam int EDGE1_POL_BIT = 30;
	localparam int EDGE1_SEL_LSB = 26;
	localparam int EDGE2_STAT_BIT = 25;
	localparam int EDGE1_STAT_BIT = 24;
	localparam int EDGE2_MODE_BIT = 23;
	localparam int EDGE2_POL_BIT = 22;
	localparam int EDGE2_SEL_LSB = 18;
	localparam int ENABLE_BIT = 15;
	localparam int IDLE_STOP_BIT = 13;
	localparam int TIME_GEN_BIT = 12;
	localparam int EDGE_PASS_BIT = 11;
	localparam int EDGE_SEQ_BIT = 10;
	localparam int DISCHARGE_BIT = 9;
	localparam int TRIG_EN_BIT = 8;
	localparam int TRIM_LSB = 2;
	localparam int TRIM_W = 6;
	localparam int RANGE_LSB = 0;
	localparam int RANGE_W = 2;
	localparam int SEL_W = 4;

	localparam logic [SEL_W-1:0] SEL_EDGE2_CMP2 = 4'hE;
	localparam logic [RANGE_W-1:0] RANGE_X1000 = 2'h0;
	localparam logic [RANGE_W-1:0] RANGE_X1 = 2'h1;
	localparam logic [RANGE_W-1:0] RANGE_X10 = 2'h2;
	localparam logic [RANGE_W-1:0] RANGE_X100 = 2'h3;
endpackage

// *** src/edge_qualifier.sv ***
// one edge channel: source select, polarity and edge or level detection
// assumes its source vector is already in the ref_clk domain
`timescale 1ns/1ps
module edge_qualifier (
	// clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// configuration
	input wire logic [charge_time_pkg::SRC_W-1:0] sources,
	input wire logic [charge_time_pkg::SEL_W-1:0] source_select,
	input wire logic edge_sensitive,
	input wire logic polarity,
	// detection
	output logic hit
);
	import charge_time_pkg::*;

	typedef struct packed {
		logic prev;
	} chan_s;

	chan_s s;
	chan_s next_s;
	logic level;

	always_comb begin
		level = sources[source_select];
		next_s = s;
		next_s.prev = level;
		if (edge_sensitive) begin
			hit = polarity ? (level && !s.prev) : (!level && s.prev);
		end else begin
			hit = polarity ? level : !level;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	edge_needs_change_a: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		(edge_sensitive && hit) |-> (level != s.prev) && (level == polarity))
		else $error("edge hit without a matching transition");

	level_follows_a: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		!edge_sensitive |-> (hit == (level == polarity)))
		else $error("level hit disagrees with polarity");
endmodule

// *** src/charge_time_unit.sv ***
// control register and edge qualification of the charge-time unit
// assumes a strobe-style register port and asynchronous pins and comparators
//
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/1ps
module charge_time_unit (
	// clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// register port
	input wire logic [charge_time_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [charge_time_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [charge_time_pkg::DATA_W-1:0] reg_rdata,
	// device power state
	input wire logic device_idle,
	// on-chip trigger events, same clock
	input wire logic timer1_event,
	input wire logic compare1_event,
	input wire logic [charge_time_pkg::CAP_N:1] capture_event,
	// asynchronous trigger sources
	input wire logic [charge_time_pkg::PIN_N:1] external_edge_pin,
	input wire logic [charge_time_pkg::CMP_N:1] comparator_output,
	// analog control
	output logic current_source_on,
	output logic source_discharge,
	output logic [charge_time_pkg::TRIM_W-1:0] current_trim,
	output logic [charge_time_pkg::RANGE_W-1:0] current_range,
	// event outputs
	output logic trigger_out,
	output logic delay_pulse_out,
	output logic edge1_status,
	output logic edge2_status
);
	import charge_time_pkg::*;

	typedef struct packed {
		logic [SYNC_W-1:0] meta;
		logic [SYNC_W-1:0] sync;
		logic [DATA_W-1:0] ctrl;
		logic [DATA_W-1:0] rdata;
		logic bus_clk_div;
		logic trig;
		logic delay;
		logic charge;
		logic discharge;
		logic [TRIM_W-1:0] trim;
		logic [RANGE_W-1:0] range;
	} unit_s;

	unit_s s;
	unit_s next_s;

	logic [PIN_N:1] pin_s;
	logic [CMP_N:1] cmp_s;
	logic [SRC_W-1:0] src [2];
	logic [SEL_W-1:0] sel [2];
	logic [1:0] mode;
	logic [1:0] pol;
	logic [1:0] raw_hit;
	logic running;
	logic pass;
	logic hit1;
	logic hit2;
	logic reg_sel;
	logic reg_wr;

	assign pin_s = s.sync[PIN_N-1:0];
	assign cmp_s = s.sync[SYNC_W-1:PIN_N];

	// edge1 source map
	assign src[0] = {cmp_s[3], cmp_s[2], cmp_s[1],
		capture_event[3], capture_event[2], capture_event[1],
		pin_s[8], pin_s[7], pin_s[6], pin_s[5], pin_s[4], pin_s[3],
		pin_s[1], pin_s[2], compare1_event, timer1_event};
	// edge2 source map; the bus clock appears as a half-rate toggle
	assign src[1] = {cmp_s[3], cmp_s[2], cmp_s[1], s.bus_clk_div,
		capture_event[3], capture_event[2], capture_event[1],
		pin_s[13], pin_s[12], pin_s[11], pin_s[10], pin_s[9],
		pin_s[1], pin_s[2], compare1_event, timer1_event};

	assign sel[0] = s.ctrl[EDGE1_SEL_LSB +: SEL_W];
	assign sel[1] = s.ctrl[EDGE2_SEL_LSB +: SEL_W];
	assign mode = {s.ctrl[EDGE2_MODE_BIT], s.ctrl[EDGE1_MODE_BIT]};
	assign pol = {s.ctrl[EDGE2_POL_BIT], s.ctrl[EDGE1_POL_BIT]};

	generate
		for (genvar ch = 0; ch < 2; ch++) begin : g_chan
			edge_qualifier u_qual (
				.ref_clk(ref_clk),
				.arst_n(arst_n),
				.sources(src[ch]),
				.source_select(sel[ch]),
				.edge_sensitive(mode[ch]),
				.polarity(pol[ch]),
				.hit(raw_hit[ch])
			);
		end
	endgenerate

	always_comb begin
		next_s = s;
		// two-stage synchroniser for pins and comparators
		next_s.meta = {comparator_output, external_edge_pin};
		next_s.sync = s.meta;
		next_s.bus_clk_div = !s.bus_clk_div;

		// run gating
		running = s.ctrl[ENABLE_BIT]
			&& !(s.ctrl[IDLE_STOP_BIT] && device_idle);
		pass = running && s.ctrl[EDGE_PASS_BIT];
		hit1 = pass && raw_hit[0];
		hit2 = pass && raw_hit[1]
			&& (!s.ctrl[EDGE_SEQ_BIT] || s.ctrl[EDGE1_STAT_BIT]);

		// register port
		reg_sel = (reg_addr == CTRL_OFFSET);
		reg_wr = reg_write && reg_sel;
		if (reg_wr) begin
			next_s.ctrl = reg_wdata & CTRL_IMPL_MASK;
		end
		// a qualified edge in the clearing cycle still wins
		if (hit1) begin
			next_s.ctrl[EDGE1_STAT_BIT] = 1'b1;
		end
		if (hit2) begin
			next_s.ctrl[EDGE2_STAT_BIT] = 1'b1;
		end
		next_s.rdata = (reg_read && reg_sel) ? s.ctrl : '0;

		// outputs
		next_s.trig = hit2 && s.ctrl[TRIG_EN_BIT];
		next_s.charge = running
			&& (s.ctrl[EDGE1_STAT_BIT] ^ s.ctrl[EDGE2_STAT_BIT]);
		next_s.delay = running && s.ctrl[TIME_GEN_BIT]
			&& s.ctrl[EDGE1_STAT_BIT] && !s.ctrl[EDGE2_STAT_BIT];
		next_s.discharge = s.ctrl[DISCHARGE_BIT];
		next_s.trim = s.ctrl[TRIM_LSB +: TRIM_W];
		next_s.range = s.ctrl[RANGE_LSB +: RANGE_W];
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			s <= '0;
			s.ctrl <= CTRL_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign reg_rdata = s.rdata;
	assign current_source_on = s.charge;
	assign source_discharge = s.discharge;
	assign current_trim = s.trim;
	assign current_range = s.range;
	assign trigger_out = s.trig;
	assign delay_pulse_out = s.delay;
	assign edge1_status = s.ctrl[EDGE1_STAT_BIT];
	assign edge2_status = s.ctrl[EDGE2_STAT_BIT];

	reserved_read_zero_a: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		(reg_rdata & ~CTRL_IMPL_MASK) == '0)
		else $error("reserved bits read as one");

	read_data_timing_a: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		(reg_read && reg_addr == CTRL_OFFSET) |=> reg_rdata == $past(s.ctrl)
		##1 ($past(reg_read && reg_addr == CTRL_OFFSET) || reg_rdata == '0))
		else $error("read data wrong or held too long");

	disabled_no_set_a: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		(!s.ctrl[ENABLE_BIT] && !edge1_status && !reg_wr) |=> !edge1_status)
		else $error("edge1 set while module disabled");

	idle_halts_a: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		(s.ctrl[IDLE_STOP_BIT] && device_idle && !edge2_status && !reg_wr)
		|=> !edge2_status)
		else $error("edge2 set while halted in idle");

	blocked_edges_a: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		(!s.ctrl[EDGE_PASS_BIT] && !edge1_status && !reg_wr) |=> !edge1_status)
		else $error("edge1 set while edges blocked");

	sequence_order_a: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		(s.ctrl[EDGE_SEQ_BIT] && !edge1_status && !edge2_status && !reg_wr)
		|=> !edge2_status)
		else $error("edge2 accepted before edge1");

	status_sticky_a: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		(edge1_status && !reg_wr) |=> edge1_status)
		else $error("edge1 status lost without a write");

	qualified_set_a: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		hit1 |=> edge1_status)
		else $error("qualified edge1 did not set status");

	trigger_cause_a: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		trigger_out |-> $past(s.ctrl[TRIG_EN_BIT]) && edge2_status)
		else $error("trigger without enable and edge2");

	delay_gate_a: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		delay_pulse_out |-> $past(s.ctrl[TIME_GEN_BIT])
		&& $past(edge1_status) && !$past(edge2_status))
		else $error("delay pulse without time generation");

	discharge_follow_a: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		##1 source_discharge == $past(s.ctrl[DISCHARGE_BIT]))
		else $error("discharge output not following its bit");

	trim_range_a: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		##1 {current_trim, current_range}
		== $past(s.ctrl[RANGE_LSB +: TRIM_W + RANGE_W]))
		else $error("trim or range output stale");
endmodule

// *** dv/tb_top.sv ***
// self-checking bench for the charge-time unit control register and edges
// assumes the unit alone, driven by the bench at rising edges of ref_clk
`timescale 1ns/1ps
module tb_top;
	import charge_time_pkg::*;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [ADDR_W-1:0] reg_addr = 8'h00;
	logic [DATA_W-1:0] reg_wdata = 32'h00000000;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic device_idle = 1'b0;
	logic timer1_event = 1'b0;
	logic [PIN_N:1] external_edge_pin = 13'h0000;
	logic [CAP_N:1] capture_event = 3'h0;
	logic [CMP_N:1] comparator_output = 3'h0;
	logic [DATA_W-1:0] reg_rdata;
	logic current_source_on, source_discharge, trigger_out;
	logic delay_pulse_out, edge1_status, edge2_status;
	logic [TRIM_W-1:0] current_trim;
	logic [RANGE_W-1:0] current_range;
	int err_total = 0;
	int n_compared = 0;
	int cycles = 0;
	int trig_count = 0;

	charge_time_unit dut (.ref_clk(ref_clk), .arst_n(arst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata),
		.device_idle(device_idle), .timer1_event(timer1_event),
		.compare1_event(1'b0), .capture_event(capture_event),
		.external_edge_pin(external_edge_pin),
		.comparator_output(comparator_output),
		.current_source_on(current_source_on),
		.source_discharge(source_discharge), .current_trim(current_trim),
		.current_range(current_range), .trigger_out(trigger_out),
		.delay_pulse_out(delay_pulse_out), .edge1_status(edge1_status),
		.edge2_status(edge2_status));

	always #50 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (trigger_out === 1'b1)
			trig_count <= trig_count + 1;
		if (cycles == 5000) begin
			err_total = err_total + 1;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("mismatches %0d of %0d compared", err_total, n_compared);
		if (err_total == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge ref_clk);
		reg_write <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge ref_clk);
		reg_read <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask

	task automatic pin(input logic v);
		@(posedge ref_clk);
		external_edge_pin[1] <= v;
		repeat (6) @(posedge ref_clk);
		#1;
	endtask

	task automatic tick_timer();
		@(posedge ref_clk);
		timer1_event <= 1'b1;
		@(posedge ref_clk);
		timer1_event <= 1'b0;
		repeat (4) @(posedge ref_clk);
		#1;
	endtask

	task automatic test_map();
		rd(8'h00, 32'h00000000);
		wr(8'h04, 32'hFFFFFFFF);
		rd(8'h00, 32'h00000000);
		rd(8'h04, 32'h00000000);
		wr(8'h00, 32'hFFFFFFFF);
		rd(8'h00, CTRL_IMPL_MASK);
		wr(8'h00, 32'h00000284);
		@(posedge ref_clk);
		#1 chk(32'(current_trim), 32'h21);
		chk(32'(current_range), 32'(RANGE_X1000));
		chk(32'(source_discharge), 32'h1);
		wr(8'h00, 32'h0000007E);
		@(posedge ref_clk);
		#1 chk(32'(current_trim), 32'h1F);
		chk(32'(current_range), 32'(RANGE_X10));
		chk(32'(source_discharge), 32'h0);
	endtask

	task automatic test_edge1();
		wr(8'h00, 32'hCC008000);
		pin(1'b1);
		chk(32'(edge1_status), 32'h0);
		pin(1'b0);
		wr(8'h00, 32'hCC00A800);
		device_idle <= 1'b1;
		pin(1'b1);
		chk(32'(edge1_status), 32'h0);
		device_idle <= 1'b0;
		pin(1'b0);
		chk(32'(edge1_status), 32'h0);
		pin(1'b1);
		chk(32'(edge1_status), 32'h1);
		rd(8'h00, 32'hCF00A800);
		wr(8'h00, 32'h0C008800);
		#1 chk(32'(edge1_status), 32'h0);
		pin(1'b0);
		chk(32'(edge1_status), 32'h1);
	endtask

	task automatic test_seq();
		int t0;
		// edges qualified by the old setup win over the first write
		wr(8'h00, 32'hCCC08D00);
		wr(8'h00, 32'hCCC08D00);
		t0 = trig_count;
		tick_timer();
		chk(32'(edge2_status), 32'h0);
		pin(1'b1);
		chk(32'(current_source_on), 32'h1);
		tick_timer();
		chk(32'(edge2_status), 32'h1);
		chk(32'(current_source_on), 32'h0);
		chk(32'(trig_count - t0), 32'h1);
		rd(8'h00, 32'hCFC08D00);
		wr(8'h00, 32'hCCC00D00);
		pin(1'b0);
		pin(1'b1);
		chk(32'(edge1_status), 32'h0);
	endtask

	task automatic test_delay();
		wr(8'h00, 32'h01389000);
		repeat (2) @(posedge ref_clk);
		#1 chk(32'(delay_pulse_out), 32'h1);
		chk(32'(current_source_on), 32'h1);
		wr(8'h00, 32'h01388000);
		repeat (2) @(posedge ref_clk);
		#1 chk(32'(delay_pulse_out), 32'h0);
	endtask

	task automatic test_sources();
		wr(8'h00, 32'hF0788800);
		repeat (4) @(posedge ref_clk);
		#1 chk(32'(edge1_status), 32'h0);
		chk(32'(edge2_status), 32'h0);
		@(posedge ref_clk);
		capture_event[3] <= 1'b1;
		comparator_output[2] <= 1'b1;
		@(posedge ref_clk);
		capture_event[3] <= 1'b0;
		repeat (5) @(posedge ref_clk);
		#1 chk(32'(edge1_status), 32'h1);
		chk(32'(edge2_status), 32'h1);
		// bus clock source: status cleared with edges blocked, then passed
		wr(8'h00, 32'h00F08000);
		wr(8'h00, 32'h00F08800);
		#1 chk(32'(edge2_status), 32'h0);
		repeat (2) @(posedge ref_clk);
		#1 chk(32'(edge2_status), 32'h1);
	endtask

	initial begin
		repeat (5) @(posedge ref_clk);
		arst_n <= 1'b1;
		test_map();
		test_edge1();
		test_seq();
		test_delay();
		test_sources();
		stop_test();
	end
endmodule
